// ### core/wdte_pkg.sv
/*
  Shared constants for the watchdog timeout event stage: register byte
  offsets, field positions, reset values, timing counts and the address
  decode used by the bus slave, which gates the bank's strobes with it.
  Assumes a 32-bit APB with 12 address bits and a 20 MHz clock.
*/
`default_nettype none
package wdte_pkg;
  // Register byte offsets (one aligned 32-bit word each)
  localparam logic [11:0] OFS_LOAD = 12'h000;
  localparam logic [11:0] OFS_VALUE = 12'h004;
  localparam logic [11:0] OFS_CTRL = 12'h008;
  localparam logic [11:0] OFS_RESTART = 12'h00C;
  localparam logic [11:0] OFS_TCOUNT = 12'h010;
  localparam logic [11:0] OFS_ITHR = 12'h014;
  localparam logic [11:0] OFS_RTHR = 12'h018;
  localparam logic [11:0] OFS_ALARM = 12'h01C;
  localparam logic [11:0] OFS_IND = 12'h020;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h024;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h028;
  // Control field positions
  localparam int CTRL_EXPIRY_INTERRUPT_ENABLE_BIT = 0;
  localparam int CTRL_EXPIRY_RESET_ENABLE_BIT = 1;
  localparam int CTRL_DOEN_BIT = 2;
  localparam int CTRL_W = 3;
  // Single-bit flag registers sit in bit 0
  localparam int FLAG_BIT = 0;
  // Interrupt status layout (mask uses the same)
  localparam int EV_EXPIRY_BIT = 0;
  localparam int EV_INT_BIT = 1;
  localparam int EV_RST_BIT = 2;
  localparam int EV_W = 3;
  // Reset values
  localparam logic [7:0] LOAD_RST = 8'hFF;
  localparam logic [7:0] VALUE_RST = 8'hFF;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] TCOUNT_RST = 8'h00;
  localparam logic [7:0] ITHR_RST = 8'h00;
  localparam logic [7:0] RTHR_RST = 8'h00;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [7:0] TCOUNT_MAX = 8'hFF;
  // Timing: one countdown step per tick period
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;

  // Address decode used by the slave (error answer and strobe gating)
  function automatic logic is_mapped(input logic [11:0] addr);
    is_mapped = (addr[1:0] == 2'h0) && (addr <= OFS_IRQ_MASK);
  endfunction
endpackage
`default_nettype wire

// ### core/wdte_reg_if.sv
/*
  Register access strobes between the APB slave and the register bank.
  Assumes both ends run on the same clock; strobes last one cycle.
*/
`default_nettype none
interface wdte_reg_if;
  logic wr_stb;        // Completed write, one cycle
  logic rd_stb;        // Completed read, one cycle
  logic [11:0] addr;   // Byte address of the access
  logic [31:0] wdata;  // Write data
  logic [31:0] rdata;  // Read word of the addressed register
  modport bus(output wr_stb, output rd_stb, output addr, output wdata, input rdata);
  modport regs(input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### core/wdte_countdown.sv
/*
  Watchdog down-counter: steps once per tick from the load value to zero
  and pulses expiry on reaching zero; a restart reloads it.
  Assumes restart and load are synchronous to clock_in.
*/
`default_nettype none
module wdte_countdown #(
  parameter int TICK_CYCLES = wdte_pkg::TICK_CYCLES
) (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Control
  input wire logic run_in,
  input wire logic restart_in,
  input wire logic [7:0] load_in,
  // Status
  output logic [7:0] value_out,
  output logic expire_out
);
  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] PRESC_LAST = PW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 1) begin : g_chk
    $error("TICK_CYCLES must be at least 1");
  end

  typedef struct packed {
    logic [PW-1:0] presc; // Cycles within the current tick
    logic [7:0] value;    // Current count
    logic expire;         // Expiry pulse
  } wdte_cd_type;

  localparam wdte_cd_type CD_RST = '{presc: '0, value: wdte_pkg::VALUE_RST, expire: 1'b0};

  wdte_cd_type st;
  wdte_cd_type next_st;

  // Next state: restart beats stepping so a late kick always counts
  always_comb begin
    next_st = st;
    next_st.expire = 1'b0;
    if (restart_in) begin
      next_st.value = load_in;
      next_st.presc = '0;
    end else if (run_in) begin
      if (st.presc == PRESC_LAST) begin
        next_st.presc = '0;
        // Reaching zero is the expiry; the next tick reloads
        if (st.value == 8'h01) begin
          next_st.value = 8'h00;
          next_st.expire = 1'b1;
        end else if (st.value == 8'h00) begin
          next_st.value = load_in;
        end else begin
          next_st.value = st.value - 8'h01;
        end
      end else begin
        next_st.presc = st.presc + PW'(1);
      end
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= CD_RST;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign value_out = st.value;
  assign expire_out = st.expire;

  expiry_at_zero_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $rose(expire_out) |-> (value_out == 8'h00) && ($past(value_out) == 8'h01))
    else $error("expiry without reaching zero");
  restart_reload_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ce_in && restart_in |=> value_out == $past(load_in))
    else $error("restart did not reload the counter");
endmodule
`default_nettype wire

// ### core/wdte_apb_slave.sv
/*
  APB slave for the watchdog event stage: zero wait states, registered
  read data, error answer on unmapped addresses.
  Assumes an APB master that holds its request until pready is seen.
*/
`default_nettype none
module wdte_apb_slave (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Register side
  wdte_reg_if.bus rb
);
  typedef struct packed {
    logic [31:0] prdata; // Read word captured before completion
  } wdte_apb_type;

  wdte_apb_type st;
  wdte_apb_type next_st;
  logic access;
  logic mapped;

  // Completion only on enabled cycles, so a frozen block stalls the master
  assign access = psel_in && penable_in && ce_in;
  assign mapped = wdte_pkg::is_mapped(paddr_in);

  // Track the addressed word until the completing edge; read side
  // effects act at that edge, so the word seen is the one before them
  always_comb begin
    next_st = st;
    if (psel_in && !pwrite_in) begin
      next_st.prdata = mapped ? rb.rdata : 32'h0000_0000;
    end
  end

  // Read data register
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign pready_out = access;
  assign pslverr_out = access && !mapped;
  assign prdata_out = st.prdata;
  assign rb.wr_stb = access && pwrite_in && mapped;
  assign rb.rd_stb = access && !pwrite_in && mapped;
  assign rb.addr = paddr_in;
  assign rb.wdata = pwdata_in;
endmodule
`default_nettype wire

// ### core/wdte_event_top.sv
/*
  Watchdog timeout event stage: counts expiries, compares the count with
  the interrupt and reset thresholds, holds the alarm flag and the
  read-clear interrupt indicator, and gathers events into a masked
  interrupt line. Holds the countdown and the APB slave.
  Assumes one clock at 20 MHz and inputs synchronous to it.
*/
// Implementation choice: the APB register port.
`default_nettype none
module wdte_event_top #(
  parameter int TICK_CYCLES = wdte_pkg::TICK_CYCLES
) (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Watchdog actions
  output logic wdt_irq_out,
  output logic rst_req_out,
  output logic alarm_out,
  // Masked event interrupt
  output logic irq_out
);
  typedef struct packed {
    logic [7:0] load;           // Countdown load value
    logic [2:0] ctrl;           // Action enables
    logic [7:0] tcount;         // Timeout occurrence count
    logic [7:0] ithr;           // Interrupt threshold
    logic [7:0] rthr;           // Reset threshold
    logic alarm;                // Sticky alarm flag
    logic ind;                  // Interrupt indicator
    logic wdt_irq;              // Pending watchdog interrupt
    logic rst_req;              // Reset request pulse
    logic cmp_pend;             // Compare due this cycle
    logic [2:0] status;         // Sticky event bits
    logic [2:0] mask;           // Event mask
    logic alarm_pin;            // Registered alarm output
    logic irq;                  // Registered event interrupt
  } wdte_state_type;

  localparam wdte_state_type ST_RST = '{
    load: wdte_pkg::LOAD_RST,
    ctrl: wdte_pkg::CTRL_RST,
    tcount: wdte_pkg::TCOUNT_RST,
    ithr: wdte_pkg::ITHR_RST,
    rthr: wdte_pkg::RTHR_RST,
    alarm: 1'b0,
    ind: 1'b0,
    wdt_irq: 1'b0,
    rst_req: 1'b0,
    cmp_pend: 1'b0,
    status: '0,
    mask: wdte_pkg::MASK_RST,
    alarm_pin: 1'b0,
    irq: 1'b0
  };

  wdte_state_type st;      // Registered state
  wdte_state_type next_st; // Next state
  wdte_reg_if rb();        // Strobes from the bus slave
  logic expiry;            // One-cycle expiry from the countdown
  logic [7:0] cd_value;    // Current countdown value
  logic restart;           // Restart write strobe
  logic wr_hit;            // Write strobe qualifier
  logic rd_hit;            // Read strobe qualifier

  // Bus slave: zero wait states, data captured before side effects
  wdte_apb_slave u_apb (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .rb(rb.bus)
  );

  // Any value written to the restart word reloads the countdown
  assign restart = rb.wr_stb && (rb.addr == wdte_pkg::OFS_RESTART);

  // Countdown only runs once some action is enabled, so an idle
  // block after reset does not pile up expiries nobody asked for
  wdte_countdown #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_cd (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .run_in(|st.ctrl),
    .restart_in(restart),
    .load_in(st.load),
    .value_out(cd_value),
    .expire_out(expiry)
  );

  assign wr_hit = rb.wr_stb;
  assign rd_hit = rb.rd_stb;

  // Read word of each register; reserved bits read as zero
  function automatic logic [31:0] read_word(input logic [11:0] addr, input wdte_state_type s,
                                            input logic [7:0] value);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (addr)
      wdte_pkg::OFS_LOAD: w[7:0] = s.load;
      wdte_pkg::OFS_VALUE: w[7:0] = value;
      wdte_pkg::OFS_CTRL: w[2:0] = s.ctrl;
      wdte_pkg::OFS_TCOUNT: w[7:0] = s.tcount;
      wdte_pkg::OFS_ITHR: w[7:0] = s.ithr;
      wdte_pkg::OFS_RTHR: w[7:0] = s.rthr;
      wdte_pkg::OFS_ALARM: w[wdte_pkg::FLAG_BIT] = s.alarm;
      wdte_pkg::OFS_IND: w[wdte_pkg::FLAG_BIT] = s.ind;
      wdte_pkg::OFS_IRQ_STATUS: w[2:0] = s.status;
      wdte_pkg::OFS_IRQ_MASK: w[2:0] = s.mask;
      default: w = 32'h0000_0000; // Restart word reads as zero
    endcase
    read_word = w;
  endfunction

  assign rb.rdata = read_word(rb.addr, st, cd_value);

  // Next state. Order matters: software clears come first and hardware
  // sets after them, so an event in the clearing cycle is never lost
  always_comb begin
    next_st = st;
    next_st.rst_req = 1'b0;
    next_st.cmp_pend = 1'b0;
    // Register writes
    if (wr_hit) begin
      unique case (rb.addr)
        wdte_pkg::OFS_LOAD: next_st.load = rb.wdata[7:0];
        wdte_pkg::OFS_CTRL: next_st.ctrl = rb.wdata[2:0];
        wdte_pkg::OFS_TCOUNT: next_st.tcount = wdte_pkg::TCOUNT_RST;
        wdte_pkg::OFS_ITHR: next_st.ithr = rb.wdata[7:0];
        wdte_pkg::OFS_RTHR: next_st.rthr = rb.wdata[7:0];
        wdte_pkg::OFS_ALARM: begin
          // Writing one to the flag is the only way to drop the alarm
          if (rb.wdata[wdte_pkg::FLAG_BIT]) begin
            next_st.alarm = 1'b0;
          end
        end
        wdte_pkg::OFS_IRQ_STATUS: next_st.status = st.status & ~rb.wdata[2:0];
        wdte_pkg::OFS_IRQ_MASK: next_st.mask = rb.wdata[2:0];
        default: begin
          // Read-only words ignore writes
        end
      endcase
    end
    // Read side effects act at the completing edge
    if (rd_hit && (rb.addr == wdte_pkg::OFS_TCOUNT)) begin
      next_st.wdt_irq = 1'b0;
    end
    if (rd_hit && (rb.addr == wdte_pkg::OFS_IND)) begin
      next_st.ind = 1'b0;
    end
    // Expiry: count it, raise the alarm, schedule the compare
    if (expiry) begin
      // Saturates at the top so the count never wraps below a threshold
      if (next_st.tcount != wdte_pkg::TCOUNT_MAX) begin
        next_st.tcount = next_st.tcount + 8'h01;
      end
      next_st.alarm = 1'b1;
      next_st.status[wdte_pkg::EV_EXPIRY_BIT] = 1'b1;
      next_st.cmp_pend = 1'b1;
    end
    // Compare against the incremented count, once per expiry
    if (st.cmp_pend) begin
      if ((st.tcount > st.ithr) && st.ctrl[wdte_pkg::CTRL_EXPIRY_INTERRUPT_ENABLE_BIT]) begin
        next_st.wdt_irq = 1'b1;
        next_st.ind = 1'b1;
        next_st.status[wdte_pkg::EV_INT_BIT] = 1'b1;
      end
      if ((st.tcount > st.rthr) && st.ctrl[wdte_pkg::CTRL_EXPIRY_RESET_ENABLE_BIT]) begin
        next_st.rst_req = 1'b1;
        next_st.status[wdte_pkg::EV_RST_BIT] = 1'b1;
      end
    end
    // Outputs from flip-flops, computed from the next flag values
    next_st.alarm_pin = next_st.alarm && next_st.ctrl[wdte_pkg::CTRL_DOEN_BIT];
    next_st.irq = |(next_st.status & next_st.mask);
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= ST_RST;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign wdt_irq_out = st.wdt_irq;
  assign rst_req_out = st.rst_req;
  assign alarm_out = st.alarm_pin;
  assign irq_out = st.irq;

  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  count_incr_a: assert property (
    ce_in && expiry && !(wr_hit && rb.addr == wdte_pkg::OFS_TCOUNT) && st.tcount != wdte_pkg::TCOUNT_MAX
    |=> st.tcount == $past(st.tcount) + 8'h01)
    else $error("count did not step by one on expiry");
  irq_threshold_a: assert property (
    ce_in && st.cmp_pend && st.ctrl[wdte_pkg::CTRL_EXPIRY_INTERRUPT_ENABLE_BIT] && (st.tcount > st.ithr)
    |=> wdt_irq_out && st.ind)
    else $error("interrupt missing above threshold");
  rst_threshold_a: assert property (
    ce_in && st.cmp_pend && st.ctrl[wdte_pkg::CTRL_EXPIRY_RESET_ENABLE_BIT] && (st.tcount > st.rthr)
    |=> rst_req_out)
    else $error("reset request missing above threshold");
  ithr_reset_a: assert property (
    nrst_in && !$past(nrst_in) |-> st.ithr == wdte_pkg::ITHR_RST)
    else $error("interrupt threshold not zero after reset");
  rthr_reset_a: assert property (
    nrst_in && !$past(nrst_in) |-> st.rthr == wdte_pkg::RTHR_RST && !st.alarm)
    else $error("reset threshold or alarm not clear after reset");
  alarm_sticky_a: assert property (
    ce_in && expiry |=> st.alarm ##1 (st.alarm || $past(wr_hit && rb.addr == wdte_pkg::OFS_ALARM)))
    else $error("alarm not set or dropped without a clear");
  ind_read_clear_a: assert property (
    ce_in && rd_hit && rb.addr == wdte_pkg::OFS_IND && !st.cmp_pend |=> !st.ind)
    else $error("indicator not cleared by read");
  tcount_access_a: assert property (
    ce_in && rd_hit && rb.addr == wdte_pkg::OFS_TCOUNT && !st.cmp_pend |=> !wdt_irq_out)
    else $error("count read did not clear the interrupt");
  alarm_gate_a: assert property (
    alarm_out |-> $past(ce_in) && st.alarm && st.ctrl[wdte_pkg::CTRL_DOEN_BIT])
    else $error("alarm pin driven while disabled or flag clear");
  compare_once_a: assert property (
    $rose(rst_req_out) |-> $past(st.cmp_pend) ##1 (!rst_req_out || !$past(ce_in)))
    else $error("reset request without a single compare");

  expiry_to_irq_c: cover property (ce_in && expiry ##1 st.cmp_pend ##1 wdt_irq_out);
  reset_req_c: cover property (rst_req_out);
  ind_read_c: cover property (st.ind && rd_hit && rb.addr == wdte_pkg::OFS_IND);
endmodule
`default_nettype wire

// ### bench/wdte_event_top_tb_top.sv
/*
  Self-checking bench for the watchdog timeout event stage: APB master
  tasks, an integer model of the occurrence count, thresholds and flags.
  Assumes the event top with a short tick and ce_in held high.
*/
`default_nettype none
module wdte_event_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Short tick keeps one expiry period near 84 cycles
  localparam int TICKS = 4;
  localparam logic [7:0] LOAD_VAL = 8'h14;
  // Design ports
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ce_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h00000000;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic wdt_irq_out;
  logic rst_req_out;
  logic alarm_out;
  logic irq_out;
  // Bench state
  int fail_count = 0;
  int n_compared = 0;
  int seed = 46;
  int cnt = 0;
  int ithr = 1;
  int rthr = 2;
  int k;
  int bad;
  logic [31:0] r;
  logic e;

  wdte_event_top #(.TICK_CYCLES(TICKS)) uut (
    .clock_in(clock_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .wdt_irq_out(wdt_irq_out), .rst_req_out(rst_req_out),
    .alarm_out(alarm_out), .irq_out(irq_out)
  );

  // Free-running 20 MHz clock
  initial begin
    forever #25 clock_in = ~clock_in;
  end

  // Prints the counts and the verdict, then stops
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Case-equality compare; an unknown never matches
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; answer taken at the rising edge where pready is high.
  // Outputs are read right after the edge, before the design's own updates land
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clock_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    i = 0;
    // Request held until the edge at which pready is sampled high
    do begin
      @(posedge clock_in);
      i++;
    end while (pready_out !== 1'b1 && i < 20);
    rd = prdata_out;
    err = pslverr_out;
    if (pready_out !== 1'b1) begin
      fail_count++;
      $display("[FAIL] pready wait timed out");
      give_verdict();
    end
    // Released at the completing edge itself
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, d, x, y);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic y;
    apb(1'b0, a, 32'h00000000, x, y);
    chk(nm, x, exp);
  endtask

  // Waits for the alarm pin, bounded well above one expiry period
  task automatic wait_alarm();
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clock_in);
      #1;
      if (alarm_out === 1'b1) break;
    end
    if (i == 400) begin
      fail_count++;
      $display("[FAIL] alarm wait timed out");
      give_verdict();
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clock_in);
    nrst_in <= 1'b1;
    cycles(1);
    chk("outs_rst", 32'({wdt_irq_out, rst_req_out, alarm_out, irq_out}), 32'h0);
    rd_chk("ithr_rst", wdte_pkg::OFS_ITHR, 32'h0);
    rd_chk("rthr_rst", wdte_pkg::OFS_RTHR, 32'h0);
    rd_chk("alarm_rst", wdte_pkg::OFS_ALARM, 32'h0);
    rd_chk("ind_rst", wdte_pkg::OFS_IND, 32'h0);
    rd_chk("count_rst", wdte_pkg::OFS_TCOUNT, 32'h0);
    rd_chk("value_rst", wdte_pkg::OFS_VALUE, 32'hFF);
    rd_chk("mask_rst", wdte_pkg::OFS_IRQ_MASK, 32'h0);
    // Random threshold values; only the low byte is kept
    for (k = 0; k < 3; k++) begin
      r = $random(seed);
      wr(wdte_pkg::OFS_ITHR, r);
      rd_chk("ithr_rw", wdte_pkg::OFS_ITHR, r & 32'hFF);
      r = $random(seed);
      wr(wdte_pkg::OFS_RTHR, r);
      rd_chk("rthr_rw", wdte_pkg::OFS_RTHR, r & 32'hFF);
    end
    // Unmapped and unaligned places answer with an error and zero data
    apb(1'b0, 12'h02C, 32'h0, r, e);
    chk("unmapped_err", 32'(e), 32'h1);
    chk("unmapped_data", r, 32'h0);
    apb(1'b0, 12'h016, 32'h0, r, e);
    chk("unaligned_err", 32'(e), 32'h1);
    // Configure; enables go last so the countdown starts from the load
    wr(wdte_pkg::OFS_ITHR, 32'(ithr));
    wr(wdte_pkg::OFS_RTHR, 32'(rthr));
    wr(wdte_pkg::OFS_IRQ_MASK, 32'h7);
    wr(wdte_pkg::OFS_LOAD, 32'(LOAD_VAL));
    wr(wdte_pkg::OFS_RESTART, $random(seed));
    wr(wdte_pkg::OFS_CTRL, 32'h7);
    // Four expiries walk the count across both thresholds
    for (k = 1; k <= 4; k++) begin
      wr(wdte_pkg::OFS_ALARM, 32'h1);
      wait_alarm();
      cnt++;
      chk("irq_out", 32'(irq_out), 32'h1);
      cycles(1);
      chk("rst_req", 32'(rst_req_out), 32'(cnt > rthr));
      chk("wdt_irq", 32'(wdt_irq_out), 32'(cnt > ithr));
      cycles(1);
      chk("rst_pulse", 32'(rst_req_out), 32'h0);
      rd_chk("alarm_set", wdte_pkg::OFS_ALARM, 32'h1);
      rd_chk("ind", wdte_pkg::OFS_IND, 32'(cnt > ithr));
      rd_chk("ind_clr", wdte_pkg::OFS_IND, 32'h0);
      rd_chk("count", wdte_pkg::OFS_TCOUNT, 32'(cnt));
      cycles(1);
      chk("wdt_irq_clr", 32'(wdt_irq_out), 32'h0);
    end
    // Mask hides the line; status bits are sticky until written with one
    wr(wdte_pkg::OFS_IRQ_MASK, 32'h0);
    cycles(2);
    chk("irq_masked", 32'(irq_out), 32'h0);
    rd_chk("status", wdte_pkg::OFS_IRQ_STATUS, 32'h7);
    wr(wdte_pkg::OFS_IRQ_STATUS, 32'h7);
    rd_chk("status_clr", wdte_pkg::OFS_IRQ_STATUS, 32'h0);
    wr(wdte_pkg::OFS_IRQ_MASK, 32'h7);
    cycles(2);
    chk("irq_idle", 32'(irq_out), 32'h0);
    // Writing the count clears it
    wr(wdte_pkg::OFS_TCOUNT, 32'h55);
    rd_chk("count_clr", wdte_pkg::OFS_TCOUNT, 32'h0);
    // Restart reloads the countdown with the load value
    wr(wdte_pkg::OFS_RESTART, $random(seed));
    rd_chk("value_reload", wdte_pkg::OFS_VALUE, 32'(LOAD_VAL));
    // Only interrupt enabled: pin and reset request stay quiet over an expiry
    wr(wdte_pkg::OFS_CTRL, 32'h1);
    wr(wdte_pkg::OFS_RTHR, 32'h0);
    wr(wdte_pkg::OFS_ALARM, 32'h1);
    bad = 0;
    for (k = 0; k < 120; k++) begin
      cycles(1);
      if (alarm_out !== 1'b0 || rst_req_out !== 1'b0) bad++;
    end
    chk("gated_outs", 32'(bad), 32'h0);
    rd_chk("alarm_flag", wdte_pkg::OFS_ALARM, 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
